// file: rtl/aip_defines.vh
// Constants for the analog I/O and profile parameter block.
// Assumes a 16-bit parameter port with logic addresses and a 20 MHz core clock.
`ifndef AIP_DEFINES_VH
`define AIP_DEFINES_VH

// Logic addresses of the parameters
`define AIP_ADDR_AIN_FILT 16'h1164
`define AIP_ADDR_AIN_STD 16'h1470
`define AIP_ADDR_AIN_PHYS 16'h147A
`define AIP_ADDR_AOUT_STD 16'h148D
`define AIP_ADDR_AOUT_PHYS 16'h1497
`define AIP_ADDR_CMD 16'h2135
`define AIP_ADDR_STATUS 16'h2136
`define AIP_ADDR_MODE 16'h2137
`define AIP_ADDR_FUNC_MAP 16'h2138

// Reset values
`define AIP_RST_FILT 16'h0000
`define AIP_RST_AOUT 16'h0000
`define AIP_RST_MODE 1'b0

// Filter timing: one second at 20 MHz
`define AIP_CLK_HZ 20000000
`define AIP_SECOND_NS 1000000000
`define AIP_TICKS_PER_S (`AIP_CLK_HZ / 1)
`define AIP_FILT_MAX 16'h000A

// Control modes
`define AIP_MODE_STD 1'b0
`define AIP_MODE_IO 1'b1

// Command word fields
`define AIP_STD_FUNC_LSB 11
`define AIP_STD_FUNC_MSB 15
`define AIP_IO_2W_LSB 1
`define AIP_IO_3W_LSB 2
`define AIP_CMD_MSB 15

// Operating states (internal codes, not the status word low bits)
`define AIP_ST_DISABLED 3'h2
`define AIP_ST_READY 3'h3
`define AIP_ST_ON 3'h4
`define AIP_ST_ENABLED 3'h5
`define AIP_ST_FAULT 3'h0

// Status word images
`define AIP_STW_DISABLED 16'h0040
`define AIP_STW_READY 16'h0021
`define AIP_STW_ON 16'h0023
`define AIP_STW_ENABLED 16'h0027
`define AIP_STW_FAULT 16'h0008

`endif

// file: rtl/aip_lowpass.v
// First-order smoothing filter for the analog input image.
// Assumes a signed 16-bit sample on the core clock; time in whole seconds.
`timescale 1ns/10ps
`default_nettype none
`include "aip_defines.vh"

module aip_lowpass (
	input wire core_clk_i,
	input wire reset_i,
	input wire signed [15:0] sample_i,
	input wire [15:0] filt_time_i,
	output reg signed [15:0] smooth_o
);
	// Tick every 1/65536 of the set time keeps a fixed shift of 16
	localparam [31:0] TICKS_PER_S = `AIP_TICKS_PER_S;
	reg [31:0] div_cnt;
	reg signed [31:0] acc;
	wire [31:0] span;
	wire tick;
	wire signed [31:0] diff;

	assign span = (TICKS_PER_S >> 16) * {16'h0000, filt_time_i};
	assign tick = (div_cnt >= span);
	assign diff = {{16{sample_i[15]}}, sample_i} - {{16{acc[31]}}, acc[31:16]};

	always @(posedge core_clk_i) begin
		if (reset_i) begin
			div_cnt <= 32'h0000_0000;
			acc <= 32'sh0000_0000;
			smooth_o <= 16'sh0000;
		end else if (filt_time_i == 16'h0000) begin
			div_cnt <= 32'h0000_0000;
			acc <= {sample_i, 16'h0000};
			smooth_o <= sample_i;
		end else begin
			if (tick) begin
				div_cnt <= 32'h0000_0000;
				acc <= acc + diff;
			end else begin
				div_cnt <= div_cnt + 32'h0000_0001;
			end
			smooth_o <= acc[31:16];
		end
	end
endmodule // aip_lowpass
`default_nettype wire

// file: rtl/aip_params.v
// Analog I/O and profile parameter bank of a soft starter.
// Assumes a synchronous parameter write/read port from the fieldbus stack, same clock.
`timescale 1ns/10ps
`default_nettype none
`include "aip_defines.vh"

module aip_params (
	input wire core_clk_i,
	input wire reset_i,
	input wire wr_en_i,
	input wire rd_en_i,
	input wire [15:0] addr_i,
	input wire [15:0] wdata_i,
	input wire [2:0] src_chan_i,
	input wire [2:0] active_chan_i,
	input wire signed [15:0] ain_raw_i,
	input wire sensor_pt100_i,
	input wire aout_assigned_i,
	input wire signed [15:0] aout_func_value_i,
	input wire three_wire_i,
	input wire error_i,
	output reg [15:0] rdata_o,
	output reg rvalid_o,
	output reg addr_err_o,
	output reg signed [15:0] aout_value_o,
	output reg [15:0] func_bits_o,
	output reg [15:0] status_o,
	output reg mode_io_o
);
	localparam [2:0] ST_DISABLED = `AIP_ST_DISABLED;
	localparam [2:0] ST_READY = `AIP_ST_READY;
	localparam [2:0] ST_ON = `AIP_ST_ON;
	localparam [2:0] ST_ENABLED = `AIP_ST_ENABLED;
	localparam [2:0] ST_FAULT = `AIP_ST_FAULT;

	reg [15:0] filt_time;
	reg signed [15:0] ain_phys;
	wire signed [15:0] ain_std;
	reg signed [15:0] aout_std_net;
	reg signed [15:0] aout_phys_net;
	reg [15:0] cmd_word;
	reg [15:0] func_map;
	reg [2:0] state;
	reg [2:0] next_state;
	reg err_q;

	// Map a state to its status word
	function [15:0] status_of;
		input [2:0] st;
		begin
			case (st)
				ST_READY: status_of = `AIP_STW_READY;
				ST_ON: status_of = `AIP_STW_ON;
				ST_ENABLED: status_of = `AIP_STW_ENABLED;
				ST_FAULT: status_of = `AIP_STW_FAULT;
				default: status_of = `AIP_STW_DISABLED;
			endcase
		end
	endfunction

	// Mask of command bits assignable in the current mode
	function [15:0] assign_mask;
		input mode_io;
		input three_wire;
		begin
			if (!mode_io)
				assign_mask = 16'hF800;
			else if (three_wire)
				assign_mask = 16'hFFFC;
			else
				assign_mask = 16'hFFFE;
		end
	endfunction

	wire is_mapped;
	wire chan_ok;
	wire out_wr_ok;
	assign is_mapped = (addr_i == `AIP_ADDR_AIN_FILT) || (addr_i == `AIP_ADDR_AIN_STD) ||
		(addr_i == `AIP_ADDR_AIN_PHYS) || (addr_i == `AIP_ADDR_AOUT_STD) ||
		(addr_i == `AIP_ADDR_AOUT_PHYS) || (addr_i == `AIP_ADDR_CMD) ||
		(addr_i == `AIP_ADDR_STATUS) || (addr_i == `AIP_ADDR_MODE) ||
		(addr_i == `AIP_ADDR_FUNC_MAP);
	assign chan_ok = (src_chan_i == active_chan_i);
	assign out_wr_ok = wr_en_i && chan_ok && !aout_assigned_i && !err_q;

	aip_lowpass u_filter (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.sample_i(ain_phys),
		.filt_time_i(filt_time),
		.smooth_o(ain_std)
	);

	// Next operating state from the command word and error
	always @* begin
		next_state = state;
		if (err_q) begin
			next_state = ST_FAULT;
		end else begin
			case (state)
				ST_DISABLED: if (cmd_word[2:0] == 3'b110) next_state = ST_READY;
				ST_READY: begin
					if (cmd_word[3:0] == 4'b0111) next_state = ST_ON;
					else if (cmd_word[1] == 1'b0) next_state = ST_DISABLED;
				end
				ST_ON: begin
					if (cmd_word[3:0] == 4'b1111) next_state = ST_ENABLED;
					else if (cmd_word[2:0] == 3'b110) next_state = ST_READY;
					else if (cmd_word[1] == 1'b0) next_state = ST_DISABLED;
				end
				ST_ENABLED: begin
					if (cmd_word[3:0] == 4'b0111) next_state = ST_ON;
					else if (cmd_word[2:0] == 3'b110) next_state = ST_READY;
					else if (cmd_word[1] == 1'b0) next_state = ST_DISABLED;
				end
				ST_FAULT: if (cmd_word[7]) next_state = ST_DISABLED;
				default: next_state = ST_DISABLED;
			endcase
		end
	end

	always @(posedge core_clk_i) begin
		if (reset_i) begin
			filt_time <= `AIP_RST_FILT;
			ain_phys <= 16'sh0000;
			aout_std_net <= `AIP_RST_AOUT;
			aout_phys_net <= `AIP_RST_AOUT;
			cmd_word <= 16'h0000;
			func_map <= 16'h0000;
			mode_io_o <= `AIP_RST_MODE;
			state <= ST_DISABLED;
			status_o <= `AIP_STW_DISABLED;
			err_q <= 1'b0;
			aout_value_o <= 16'sh0000;
			func_bits_o <= 16'h0000;
		end else begin
			err_q <= error_i;
			ain_phys <= ain_raw_i;
			state <= next_state;
			status_o <= status_of(next_state);
			if (wr_en_i) begin
				case (addr_i)
					`AIP_ADDR_AIN_FILT:
						if (wdata_i <= `AIP_FILT_MAX) filt_time <= wdata_i;
					`AIP_ADDR_CMD:
						if (chan_ok) cmd_word <= wdata_i;
					`AIP_ADDR_MODE:
						if (state != ST_ENABLED) mode_io_o <= wdata_i[0];
					`AIP_ADDR_FUNC_MAP:
						func_map <= wdata_i;
					default: ;
				endcase
			end
			if (err_q) begin
				aout_std_net <= 16'sh0000;
				aout_phys_net <= 16'sh0000;
			end else if (out_wr_ok && addr_i == `AIP_ADDR_AOUT_STD) begin
				aout_std_net <= wdata_i;
				aout_phys_net <= wdata_i;
			end else if (out_wr_ok && addr_i == `AIP_ADDR_AOUT_PHYS) begin
				aout_phys_net <= wdata_i;
				aout_std_net <= wdata_i;
			end
			aout_value_o <= aout_assigned_i ? aout_func_value_i : aout_phys_net;
			func_bits_o <= cmd_word & func_map & assign_mask(mode_io_o, three_wire_i);
		end
	end

	// Read port, one cycle after the strobe
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			rdata_o <= 16'h0000;
			rvalid_o <= 1'b0;
			addr_err_o <= 1'b0;
		end else begin
			rvalid_o <= rd_en_i;
			addr_err_o <= (rd_en_i || wr_en_i) && !is_mapped;
			if (rd_en_i) begin
				case (addr_i)
					`AIP_ADDR_AIN_FILT: rdata_o <= filt_time;
					`AIP_ADDR_AIN_STD: rdata_o <= ain_std;
					`AIP_ADDR_AIN_PHYS: rdata_o <= ain_phys;
					`AIP_ADDR_AOUT_STD: rdata_o <= aout_assigned_i ? aout_func_value_i : aout_std_net;
					`AIP_ADDR_AOUT_PHYS: rdata_o <= aout_value_o;
					`AIP_ADDR_CMD: rdata_o <= cmd_word;
					`AIP_ADDR_STATUS: rdata_o <= status_o;
					`AIP_ADDR_MODE: rdata_o <= {15'h0000, mode_io_o};
					`AIP_ADDR_FUNC_MAP: rdata_o <= func_map;
					default: rdata_o <= 16'h0000;
				endcase
			end
		end
	end
endmodule // aip_params
`default_nettype wire

// file: verification/aip_master_model.sv
// Fieldbus master model issuing parameter accesses.
// Assumes one access at a time, signals moved at falling edges.
`timescale 1ns/10ps
`default_nettype none
module aip_master_model (
	input wire logic core_clk_i,
	input wire logic [15:0] rdata_i,
	input wire logic rvalid_i,
	output logic wr_en_o,
	output logic rd_en_o,
	output logic [15:0] addr_o,
	output logic [15:0] wdata_o,
	output logic [2:0] src_chan_o
);
	logic [2:0] chan = 3'h1;
	assign src_chan_o = chan;
	initial begin
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		addr_o = 16'hFFFF;
		wdata_o = 16'h0000;
	end
	// Released bus shows inverted values, not stale ones
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge core_clk_i);
		addr_o = a;
		wdata_o = d;
		wr_en_o = 1'b1;
		@(negedge core_clk_i);
		wr_en_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge core_clk_i);
		addr_o = a;
		rd_en_o = 1'b1;
		@(negedge core_clk_i);
		rd_en_o = 1'b0;
		addr_o = ~a;
		d = rvalid_i ? rdata_i : 16'hxxxx;
	endtask
endmodule // aip_master_model
`default_nettype wire

// file: verification/aip_params_properties.sv
// Port checker for the analog I/O and profile parameter bank.
// Assumes binding onto aip_params, one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "aip_defines.vh"
module aip_params_properties (
	input wire core_clk_i,
	input wire reset_i,
	input wire wr_en_i,
	input wire rd_en_i,
	input wire [15:0] addr_i,
	input wire [15:0] wdata_i,
	input wire [2:0] src_chan_i,
	input wire [2:0] active_chan_i,
	input wire aout_assigned_i,
	input wire three_wire_i,
	input wire error_i,
	input wire rvalid_o,
	input wire signed [15:0] aout_value_o,
	input wire [15:0] func_bits_o,
	input wire [15:0] status_o,
	input wire mode_io_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	wire aw = wr_en_i && addr_i == `AIP_ADDR_AOUT_STD && !aout_assigned_i && !error_i;
	wire own = src_chan_i == active_chan_i;
	wire quiet = !wr_en_i && !error_i && !aout_assigned_i;
	property p_take;
		quiet ##1 aw && own ##1 quiet |=> aout_value_o == $past(wdata_i, 2);
	endproperty
	a_take: assert property (p_take) else $error("output write lost");
	property p_foreign;
		quiet ##1 aw && !own ##1 quiet |=> $stable(aout_value_o);
	endproperty
	a_foreign: assert property (p_foreign) else $error("foreign write taken");
	property p_err;
		error_i [*4] |-> aout_value_o == 16'h0000;
	endproperty
	a_err: assert property (p_err) else $error("output not cleared on error");
	property p_err_st;
		error_i [*4] |-> status_o == `AIP_STW_FAULT;
	endproperty
	a_err_st: assert property (p_err_st) else $error("no fault status");
	property p_std;
		!mode_io_o && $past(!mode_io_o) |-> func_bits_o[10:0] == 11'h000;
	endproperty
	a_std: assert property (p_std) else $error("low bit active in standard");
	property p_io3;
		mode_io_o && three_wire_i && $past(mode_io_o) && $past(three_wire_i) |-> func_bits_o[1:0] == 2'b00;
	endproperty
	a_io3: assert property (p_io3) else $error("bit 1 active in three-wire");
	property p_bit0;
		func_bits_o[0] == 1'b0;
	endproperty
	a_bit0: assert property (p_bit0) else $error("bit 0 assigned");
	property p_stat;
		status_o inside {`AIP_STW_DISABLED, `AIP_STW_READY, `AIP_STW_ON, `AIP_STW_ENABLED, `AIP_STW_FAULT};
	endproperty
	a_stat: assert property (p_stat) else $error("status code unknown");
	property p_rd;
		rd_en_i |=> rvalid_o;
	endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	c_take: cover property (quiet ##1 aw && own);
	c_err: cover property (error_i [*4]);
	c_io3: cover property (mode_io_o && three_wire_i);
endmodule // aip_params_properties
bind aip_params aip_params_properties u_props (.core_clk_i, .reset_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i,
	.src_chan_i, .active_chan_i, .aout_assigned_i, .three_wire_i, .error_i, .rvalid_o, .aout_value_o,
	.func_bits_o, .status_o, .mode_io_o);
`default_nettype wire

// file: verification/aip_params_tb_top.sv
// Self-checking bench for the parameter bank.
// Assumes the master model drives the access port.
`timescale 1ns/10ps
`default_nettype none
`include "aip_defines.vh"
module aip_params_tb_top;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic wr_en_i, rd_en_i, rvalid_o, addr_err_o, mode_io_o, sensor_pt100_i, aout_assigned_i, three_wire_i, error_i;
	logic [15:0] addr_i, wdata_i, rdata_o, func_bits_o, status_o, x, cmd, rv;
	logic signed [15:0] ain_raw_i, aout_func_value_i, aout_value_o;
	logic [2:0] src_chan_i, active_chan_i;
	int n_fail = 0;
	int cmp_count = 0;
	int seed = 5925;
	// Command words and the status each should produce; ends enabled so the mode write is refused
	logic [15:0] cmd_tab [5] = '{16'h0006, 16'h0007, 16'h0006, 16'h0007, 16'h000F};
	logic [15:0] stw_tab [5] = '{`AIP_STW_READY, `AIP_STW_ON, `AIP_STW_READY, `AIP_STW_ON, `AIP_STW_ENABLED};
	initial forever #25 core_clk_i = ~core_clk_i;
	aip_master_model m (.core_clk_i, .rdata_i(rdata_o), .rvalid_i(rvalid_o), .wr_en_o(wr_en_i),
		.rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i), .src_chan_o(src_chan_i));
	aip_params uut (.core_clk_i, .reset_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .src_chan_i, .active_chan_i,
		.ain_raw_i, .sensor_pt100_i, .aout_assigned_i, .aout_func_value_i, .three_wire_i, .error_i, .rdata_o,
		.rvalid_o, .addr_err_o, .aout_value_o, .func_bits_o, .status_o, .mode_io_o);
	function automatic logic [15:0] fmask(input logic io, input logic tw);
		return !io ? 16'hF800 : (tw ? 16'hFFFC : 16'hFFFE);
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
		m.rd(a, rv);
		chk(rv, exp);
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk_i);
		n_fail++;
		results();
	end
	initial begin
		{sensor_pt100_i, aout_assigned_i, three_wire_i, error_i} = 4'h0;
		ain_raw_i = 16'sh0000;
		aout_func_value_i = 16'sh1234;
		active_chan_i = 3'h1;
		repeat (5) @(negedge core_clk_i);
		reset_i = 1'b0;
		chk(status_o, `AIP_STW_DISABLED);
		chk(aout_value_o, `AIP_RST_AOUT);
		rdc(`AIP_ADDR_AIN_FILT, `AIP_RST_FILT);
		m.rd(16'h0000, rv);
		chk(rv, 16'h0000);
		chk({15'h0000, addr_err_o}, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			x = $random(seed);
			ain_raw_i = x;
			sensor_pt100_i = x[0];
			repeat (3) @(negedge core_clk_i);
			rdc(`AIP_ADDR_AIN_PHYS, x);
			rdc(`AIP_ADDR_AIN_STD, x);
		end
		m.wr(`AIP_ADDR_AIN_FILT, `AIP_FILT_MAX);
		m.wr(`AIP_ADDR_AIN_FILT, 16'h000B);
		rdc(`AIP_ADDR_AIN_FILT, `AIP_FILT_MAX);
		m.wr(`AIP_ADDR_AIN_FILT, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			x = $random(seed);
			m.wr(i[0] ? `AIP_ADDR_AOUT_PHYS : `AIP_ADDR_AOUT_STD, x);
			repeat (2) @(negedge core_clk_i);
			chk(aout_value_o, x);
			rdc(i[0] ? `AIP_ADDR_AOUT_STD : `AIP_ADDR_AOUT_PHYS, x);
		end
		m.chan = 3'h2;
		m.wr(`AIP_ADDR_AOUT_STD, ~x);
		m.chan = 3'h1;
		repeat (2) @(negedge core_clk_i);
		chk(aout_value_o, x);
		aout_assigned_i = 1'b1;
		m.wr(`AIP_ADDR_AOUT_STD, ~x);
		rdc(`AIP_ADDR_AOUT_STD, 16'h1234);
		aout_assigned_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		chk(aout_value_o, x);
		foreach (cmd_tab[k]) begin
			m.wr(`AIP_ADDR_CMD, cmd_tab[k]);
			repeat (3) @(negedge core_clk_i);
			chk(status_o, stw_tab[k]);
		end
		m.wr(`AIP_ADDR_MODE, 16'h0001);
		repeat (2) @(negedge core_clk_i);
		chk({15'h0000, mode_io_o}, 16'h0000);
		error_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		chk(status_o, `AIP_STW_FAULT);
		error_i = 1'b0;
		chk(aout_value_o, 16'h0000);
		m.wr(`AIP_ADDR_CMD, 16'h0080);
		repeat (3) @(negedge core_clk_i);
		chk(status_o, `AIP_STW_DISABLED);
		m.wr(`AIP_ADDR_FUNC_MAP, 16'hFFFF);
		for (int k = 0; k < 3; k++) begin
			three_wire_i = k == 2;
			m.wr(`AIP_ADDR_MODE, {15'h0000, k > 0});
			cmd = ($random(seed) & 16'hFF73) | 16'h0003;
			m.wr(`AIP_ADDR_CMD, cmd);
			repeat (3) @(negedge core_clk_i);
			chk({15'h0000, mode_io_o}, {15'h0000, k > 0});
			chk(func_bits_o, cmd & fmask(k > 0, k == 2));
		end
		results();
	end
endmodule // aip_params_tb_top
`default_nettype wire
